// file: hdl/afe_pkg.sv
// Shared constants for the sensor front-end control and output logic
package afe_pkg;
  // Serial word layout
  localparam int WORD_BITS = 11;
  localparam int SEL_BITS = 3;
  localparam int DATA_BITS = 8;
  localparam logic [3:0] WORD_COUNT = 4'hB;
  // Register select codes
  localparam logic [2:0] SEL_RED_GAIN = 3'h0;
  localparam logic [2:0] SEL_RED_OFS = 3'h1;
  localparam logic [2:0] SEL_GRN_GAIN = 3'h2;
  localparam logic [2:0] SEL_GRN_OFS = 3'h3;
  localparam logic [2:0] SEL_BLU_GAIN = 3'h4;
  localparam logic [2:0] SEL_BLU_OFS = 3'h5;
  localparam logic [2:0] SEL_MODE = 3'h6;
  // Field positions
  localparam int GAIN_MSB = 7;
  localparam int GAIN_LSB = 2;
  localparam int GAIN_BITS = 6;
  localparam int MODE_PWRDN = 7;
  localparam int MODE_DIGRST = 6;
  localparam int MODE_OFSRNG = 5;
  localparam int MODE_DCREF = 4;
  localparam int MODE_ACCPL = 3;
  localparam int MODE_INVERT = 2;
  localparam int MODE_CFG_MSB = 1;
  // Reset values
  localparam logic [5:0] GAIN_RESET = 6'h00;
  localparam logic [7:0] OFS_RESET = 8'h40;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // Signal configurations
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_PIX_GO = 2'h1;
  localparam logic [1:0] CFG_PIX_RGB = 2'h2;
  localparam logic [1:0] CFG_LINE_RGB = 2'h3;
  // Output latency in conversion clocks
  localparam int LAT_LINE = 8;
  localparam int LAT_PIXEL = 6;
  localparam int RESULT_BITS = 16;
  // Pin positions on the shared bus
  localparam int PIN_LOAD = 7;
  localparam int PIN_SERIAL_DATA = 6;
  localparam int PIN_SCLK = 5;
  // Colour channel
  typedef enum logic [1:0] {CH_RED, CH_GRN, CH_BLU} chan_t;
endpackage : afe_pkg

// file: hdl/serial_load_if.sv
// Carrier between the core and the serial loader
`timescale 1ns/1ps
`default_nettype none
interface serial_load_if;
  logic enable;
  logic sclk;
  logic serial_data;
  logic strobe;
  logic wr_valid;
  logic [2:0] wr_sel;
  logic [7:0] wr_data;
  modport loader (input enable, input sclk, input serial_data, input strobe,
                  output wr_valid, output wr_sel, output wr_data);
  modport core (output enable, output sclk, output serial_data, output strobe,
                input wr_valid, input wr_sel, input wr_data);
endinterface : serial_load_if
`default_nettype wire

// file: hdl/serial_loader.sv
// Three-wire serial word assembler
`timescale 1ns/1ps
`default_nettype none
module serial_loader (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Link to the core
  serial_load_if.loader sl
);
  import afe_pkg::*;

  logic sclk_prev_q;
  logic strobe_prev_q;
  logic [3:0] count_q;
  logic [WORD_BITS-1:0] shift_q;
  logic wr_valid_q;
  logic [2:0] wr_sel_q;
  logic [7:0] wr_data_q;

  // Edge detection on the already synchronised pins
  wire sclk_rise = sl.sclk & ~sclk_prev_q;
  wire load_rise = sl.strobe & ~strobe_prev_q;
  wire full = (count_q == WORD_COUNT);
  wire take_bit = sl.enable & ~sl.strobe & sclk_rise & ~full;
  wire commit = sl.enable & load_rise & full;

  // Shift in MSB first, stop after the eleventh clock
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_prev_q <= 1'b0;
      strobe_prev_q <= 1'b1;
      count_q <= 4'h0;
      shift_q <= '0;
    end else begin
      sclk_prev_q <= sl.sclk;
      strobe_prev_q <= sl.strobe;
      if (!sl.enable || load_rise) begin
        count_q <= 4'h0;
      end else if (take_bit) begin
        count_q <= count_q + 4'h1;
        shift_q <= {shift_q[WORD_BITS-2:0], sl.serial_data};
      end
    end
  end

  // Commit only complete words on the load strobe rising edge
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_valid_q <= 1'b0;
      wr_sel_q <= 3'h0;
      wr_data_q <= 8'h00;
    end else begin
      wr_valid_q <= commit;
      if (commit) begin
        wr_sel_q <= shift_q[WORD_BITS-1:DATA_BITS];
        wr_data_q <= shift_q[DATA_BITS-1:0];
      end
    end
  end

  assign sl.wr_valid = wr_valid_q;
  assign sl.wr_sel = wr_sel_q;
  assign sl.wr_data = wr_data_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  short_word_a: assert property (load_rise && !full |=> !wr_valid_q)
    else $error("short serial word was committed");
  word_cap_a: assert property (count_q <= WORD_COUNT)
    else $error("serial bit count passed eleven");
  commit_cov: cover property (commit);
endmodule : serial_loader
`default_nettype wire

// file: hdl/afe_ctrl.sv
// Sensor front-end digital control, channel sequencing and output bus
//
// Notes on behaviour
// - Line-start high: output bus released, serial load port enabled.
// - Eleven-bit word, bits on serial clock rise, committed on strobe rise.
// - Fewer than eleven serial clocks: transaction dropped, registers untouched.
// - Serial clocks after the eleventh are ignored.
// - Top three bits select the register, low eight bits are data.
// - Converter samples on each falling conversion clock edge, except in power-down.
// - High byte after falling edge, low byte after rising edge.
// - Latency eight clocks in configs 00 and 11, six in 01 and 10.
// - Bus bits 7..0 carry result 15..8, then result 7..0.
// - Triple pixel mode samples all colours every third fall, holds green and blue.
// - Line-start high resets the colour selector to red, except in configuration 11.
// - Line-start low advances colour on every falling conversion clock edge in configs 01 and 10; config 11 advances at line end.
// - Gain and offset follow the selected colour channel.
// - Clamp strobe high clamps, low tracks; controller raises it on shielded pixels.
// - Offset is eight bits; range bit picks between two offset ranges.
// - Gain is a six-bit linear code.
// - Reset values: DC contact sensor, internal references, red, unity gain, offset code 40h.
// - Power-down keeps registers except signal configuration, which is cleared.
// - Inverted configuration complements the conversion result.
`timescale 1ns/1ps
`default_nettype none
module afe_ctrl (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Control pins from the scanner controller
  input wire logic line_start_control_i,
  input wire logic conversion_clock_i,
  input wire logic clamp_strobe_i,
  // Shared output bus and serial load pins
  input wire logic [7:0] bus_i,
  output logic [7:0] bus_o,
  output logic bus_oe_o,
  // Converter samples per colour input
  input wire logic [afe_pkg::RESULT_BITS-1:0] red_sample_i,
  input wire logic [afe_pkg::RESULT_BITS-1:0] grn_sample_i,
  input wire logic [afe_pkg::RESULT_BITS-1:0] blu_sample_i,
  // Analog front-end settings
  output logic sample_strobe_o,
  output afe_pkg::chan_t channel_o,
  output logic [afe_pkg::GAIN_BITS-1:0] gain_o,
  output logic [7:0] offset_o,
  output logic offset_range_o,
  output logic dc_ref_ext_o,
  output logic ac_coupled_o,
  output logic inverted_o,
  output logic [1:0] signal_config_o,
  output logic power_down_o,
  output logic clamp_active_o
);
  import afe_pkg::*;

  // Synchronisers: first stage is read only by the second
  logic [10:0] sync1_q;
  logic [10:0] sync2_q;
  logic cc_prev_q;
  logic ls_prev_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      cc_prev_q <= 1'b0;
      ls_prev_q <= 1'b0;
    end else begin
      sync1_q <= {line_start_control_i, conversion_clock_i, clamp_strobe_i, bus_i};
      sync2_q <= sync1_q;
      cc_prev_q <= sync2_q[9];
      ls_prev_q <= sync2_q[10];
    end
  end

  // Decoded pin levels and edges
  wire line_start = sync2_q[10];
  wire conv_clk = sync2_q[9];
  wire clamp_lvl = sync2_q[8];
  wire conv_fall = cc_prev_q & ~conv_clk;
  wire conv_rise = ~cc_prev_q & conv_clk;
  wire line_end = ls_prev_q & ~line_start;

  // Serial loader on the shared pins
  serial_load_if sl ();
  assign sl.enable = line_start;
  assign sl.sclk = sync2_q[PIN_SCLK];
  assign sl.serial_data = sync2_q[PIN_SERIAL_DATA];
  assign sl.strobe = sync2_q[PIN_LOAD];

  serial_loader u_loader (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .sl(sl)
  );

  // Register file
  logic [GAIN_BITS-1:0] gain_q [3];
  logic [7:0] ofs_q [3];
  logic [7:0] mode_q;

  wire wr = sl.wr_valid;
  wire [1:0] wr_idx = sl.wr_sel[2:1];
  wire wr_gain = wr & (sl.wr_sel < SEL_MODE) & ~sl.wr_sel[0];
  wire wr_ofs = wr & (sl.wr_sel < SEL_MODE) & sl.wr_sel[0];
  wire wr_mode = wr & (sl.wr_sel == SEL_MODE);
  wire dig_reset = wr_mode & sl.wr_data[MODE_DIGRST];
  wire [7:0] mode_new = sl.wr_data[MODE_PWRDN] ?
                        {sl.wr_data[7:MODE_CFG_MSB+1], 2'h0} : sl.wr_data;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      gain_q <= '{default: GAIN_RESET};
      ofs_q <= '{default: OFS_RESET};
      mode_q <= MODE_RESET;
    end else if (dig_reset) begin
      gain_q <= '{default: GAIN_RESET};
      ofs_q <= '{default: OFS_RESET};
      mode_q <= MODE_RESET;
    end else begin
      if (wr_gain) gain_q[wr_idx] <= sl.wr_data[GAIN_MSB:GAIN_LSB];
      if (wr_ofs) ofs_q[wr_idx] <= sl.wr_data;
      if (wr_mode) mode_q <= {mode_new[7], 1'b0, mode_new[5:0]};
    end
  end

  // Mode fields
  wire [1:0] cfg = mode_q[MODE_CFG_MSB:0];
  wire pwr_dn = mode_q[MODE_PWRDN];
  wire invert = mode_q[MODE_INVERT];
  wire pixel_rot = (cfg == CFG_PIX_GO) | (cfg == CFG_PIX_RGB);

  // Next colour in red, green, blue order
  function automatic chan_t next_chan(input chan_t c);
    case (c)
      CH_RED: next_chan = CH_GRN;
      CH_GRN: next_chan = CH_BLU;
      default: next_chan = CH_RED;
    endcase
  endfunction : next_chan

  // Colour selector
  chan_t chan_q;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      chan_q <= CH_RED;
    end else if (line_start && cfg != CFG_LINE_RGB) begin
      chan_q <= CH_RED;
    end else if (cfg == CFG_LINE_RGB) begin
      if (line_end) chan_q <= next_chan(chan_q);
    end else if (cfg == CFG_SINGLE) begin
      chan_q <= CH_RED;
    end else if (conv_fall) begin
      chan_q <= next_chan(chan_q);
    end
  end

  // Conversion value selection
  logic [RESULT_BITS-1:0] hold_grn_q;
  logic [RESULT_BITS-1:0] hold_blu_q;
  wire use_rgb = (cfg == CFG_PIX_RGB) | (cfg == CFG_LINE_RGB);
  wire [RESULT_BITS-1:0] held =
      (chan_q == CH_GRN) ? hold_grn_q : hold_blu_q;
  wire [RESULT_BITS-1:0] live =
      (chan_q == CH_GRN) ? grn_sample_i :
      (chan_q == CH_BLU) ? blu_sample_i : red_sample_i;
  wire [RESULT_BITS-1:0] raw =
      (!use_rgb || chan_q == CH_RED) ? red_sample_i :
      (cfg == CFG_PIX_RGB) ? held : live;
  wire [RESULT_BITS-1:0] conv_val = invert ? ~raw : raw;

  // Hold green and blue on the red sampling edge
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hold_grn_q <= '0;
      hold_blu_q <= '0;
    end else if (conv_fall && cfg == CFG_PIX_RGB && chan_q == CH_RED) begin
      hold_grn_q <= grn_sample_i;
      hold_blu_q <= blu_sample_i;
    end
  end

  // Latency pipeline advanced by conversion clock falling edges
  logic [RESULT_BITS-1:0] pipe_q [LAT_LINE];
  logic [RESULT_BITS-1:0] word_q;
  wire [RESULT_BITS-1:0] tap = pixel_rot ? pipe_q[LAT_PIXEL-1] : pipe_q[LAT_LINE-1];

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pipe_q <= '{default: '0};
      word_q <= '0;
    end else if (conv_fall) begin
      pipe_q[0] <= conv_val;
      for (int i = 1; i < LAT_LINE; i++) pipe_q[i] <= pipe_q[i-1];
      word_q <= tap;
    end
  end

  // Output byte: high half after the fall, low half after the rise
  logic [7:0] bus_q;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bus_q <= 8'h00;
    end else if (conv_fall) begin
      bus_q <= tap[15:8];
    end else if (conv_rise) begin
      bus_q <= word_q[7:0];
    end
  end

  // Settings for the analog side follow the selected channel
  logic [GAIN_BITS-1:0] gain_sel_q;
  logic [7:0] ofs_sel_q;
  logic strobe_q;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      gain_sel_q <= GAIN_RESET;
      ofs_sel_q <= OFS_RESET;
      strobe_q <= 1'b0;
    end else begin
      gain_sel_q <= gain_q[chan_q];
      ofs_sel_q <= ofs_q[chan_q];
      strobe_q <= conv_fall & ~pwr_dn;
    end
  end

  assign bus_o = bus_q;
  assign bus_oe_o = ~line_start & ~pwr_dn;
  assign sample_strobe_o = strobe_q;
  assign channel_o = chan_q;
  assign gain_o = gain_sel_q;
  assign offset_o = ofs_sel_q;
  assign offset_range_o = mode_q[MODE_OFSRNG];
  assign dc_ref_ext_o = mode_q[MODE_DCREF];
  assign ac_coupled_o = mode_q[MODE_ACCPL];
  assign inverted_o = invert;
  assign signal_config_o = cfg;
  assign power_down_o = pwr_dn;
  assign clamp_active_o = clamp_lvl;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  bus_release_a: assert property (line_start |-> !bus_oe_o)
    else $error("output bus driven during line start");
  red_reset_a: assert property (line_start && cfg != CFG_LINE_RGB |=> chan_q == CH_RED)
    else $error("colour selector not red during line start");
  chan_step_a: assert property (
      !line_start && conv_fall && pixel_rot |=> chan_q == next_chan($past(chan_q)))
    else $error("colour selector did not advance");
  high_byte_a: assert property (conv_fall |=> bus_o == $past(tap[15:8]))
    else $error("high byte missing after falling edge");
  low_byte_a: assert property (conv_rise |=> bus_o == $past(word_q[7:0]))
    else $error("low byte wrong after rising edge");
  gain_follow_a: assert property (
      ##1 !$past(dig_reset) && !$past(wr) |-> gain_o == gain_q[$past(chan_q)])
    else $error("gain does not follow colour");
  pdn_cfg_a: assert property (wr_mode && sl.wr_data[MODE_PWRDN] && !dig_reset
      |=> cfg == 2'h0 && pwr_dn)
    else $error("signal configuration kept over power-down");
  invert_a: assert property (conv_fall && invert |=> pipe_q[0] == ~$past(raw))
    else $error("inverted result not complemented");
  pipe_delay_a: assert property (conv_fall && !pixel_rot |=> word_q == $past(pipe_q[7]))
    else $error("line latency tap wrong");
  clamp_a: assert property ($rose(clamp_strobe_i) |-> ##[1:3] clamp_active_o)
    else $error("clamp did not follow strobe");

  write_cov: cover property (wr_mode);
  rgb_cov: cover property (cfg == CFG_PIX_RGB && conv_fall && chan_q == CH_BLU);
  line_cov: cover property (cfg == CFG_LINE_RGB && line_end);
endmodule : afe_ctrl
`default_nettype wire

// file: bench/scan_ctrl_model.sv
// Scanner controller model: conversion clock, line start, clamp, samples and serial loads
`timescale 1ns/1ps
`default_nettype none
module scan_ctrl_model (
  // System clock
  input wire logic clock_i,
  // Control pins
  output logic line_start_o,
  output logic conv_clk_o,
  output logic clamp_o,
  // Bus drive while the device has released it
  output logic [7:0] drive_o,
  // Converter samples per colour
  output logic [15:0] red_o,
  output logic [15:0] grn_o,
  output logic [15:0] blu_o
);
  // Idle pins: line start high, load strobe high, serial clock low
  initial begin
    line_start_o = 1'b1;
    conv_clk_o = 1'b1;
    clamp_o = 1'b0;
    drive_o = 8'h80;
    red_o = 16'h0000;
    grn_o = 16'hFFFF;
    blu_o = 16'h5555;
  end
  // Wait a number of falling system clock edges
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock_i);
  endtask : wait_n
  // Set line start and let it pass the synchronisers
  task automatic set_line(input logic v);
    line_start_o = v;
    wait_n(6);
  endtask : set_line
  // One serial word, MSB first; clocks past eleven carry inverted bits
  task automatic send_word(input logic [2:0] sel, input logic [7:0] data, input int nclk);
    logic [10:0] w;
    w = {sel, data};
    drive_o[4:0] = w[4:0]; // Unused pins carry noise the loader must ignore
    drive_o[7] = 1'b0;
    wait_n(4);
    for (int i = 0; i < nclk; i++) begin
      drive_o[6] = w[10 - (i % 11)] ^ (i > 10);
      wait_n(4);
      drive_o[5] = 1'b1;
      wait_n(4);
      drive_o[5] = 1'b0;
    end
    wait_n(4);
    drive_o[7] = 1'b1;
    drive_o[6] = ~drive_o[6];
    wait_n(12);
  endtask : send_word
  // Half a conversion period; fresh samples appear with the rising edge
  task automatic conv_half(input logic lvl, input logic [15:0] v);
    conv_clk_o = lvl;
    if (lvl) begin
      red_o = v;
      grn_o = ~v;
      blu_o = v ^ 16'h0F0F;
    end
    wait_n(12);
  endtask : conv_half
  // Clamp raised over shielded pixels
  task automatic set_clamp(input logic v);
    clamp_o = v;
    wait_n(6);
  endtask : set_clamp
endmodule : scan_ctrl_model
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the front-end control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
  import afe_pkg::*;
  logic clock_i;
  logic rst_i;
  logic line_start;
  logic conv_clk;
  logic clamp;
  logic [7:0] drive;
  logic [7:0] bus_i;
  logic [7:0] bus_o;
  logic bus_oe_o;
  logic [15:0] red;
  logic [15:0] grn;
  logic [15:0] blu;
  chan_t channel_o;
  logic [5:0] gain_o;
  logic [7:0] offset_o;
  logic offset_range_o;
  logic dc_ref_ext_o;
  logic ac_coupled_o;
  logic inverted_o;
  logic [1:0] signal_config_o;
  logic power_down_o;
  logic clamp_active_o;
  logic sample_strobe_o;
  int errors;
  int tests_run;
  int strobes;
  logic [5:0] gtab [3] = '{6'h2A, 6'h15, 6'h3F};
  // Shared bus level: device when enabled, controller otherwise
  assign bus_i = bus_oe_o ? bus_o : drive;
  // System clock
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  scan_ctrl_model u_model (.clock_i(clock_i), .line_start_o(line_start), .conv_clk_o(conv_clk),
    .clamp_o(clamp), .drive_o(drive), .red_o(red), .grn_o(grn), .blu_o(blu));
  afe_ctrl u_dut (.clock_i(clock_i), .rst_i(rst_i), .line_start_control_i(line_start),
    .conversion_clock_i(conv_clk), .clamp_strobe_i(clamp), .bus_i(bus_i), .bus_o(bus_o),
    .bus_oe_o(bus_oe_o), .red_sample_i(red), .grn_sample_i(grn), .blu_sample_i(blu),
    .sample_strobe_o(sample_strobe_o), .channel_o(channel_o), .gain_o(gain_o),
    .offset_o(offset_o),
    .offset_range_o(offset_range_o), .dc_ref_ext_o(dc_ref_ext_o), .ac_coupled_o(ac_coupled_o),
    .inverted_o(inverted_o), .signal_config_o(signal_config_o), .power_down_o(power_down_o),
    .clamp_active_o(clamp_active_o));
  // Count sample strobe pulses, one per conversion clock fall
  initial strobes = 0;
  always @(negedge clock_i) if (sample_strobe_o === 1'b1) strobes++;
  // Verdict and end of run
  task automatic test_done();
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // Sample value taken at fall number k
  function automatic logic [15:0] val(input int k);
    val = {k[7:0] ^ 8'hA5, k[7:0]};
  endfunction : val
  // One line of conversions in a given mode, checking bytes, channel and gain
  task automatic stream(input logic [7:0] mode, input int lat);
    logic [15:0] e;
    logic [7:0] hi;
    logic [1:0] c;
    int j;
    int n0;
    u_model.send_word(SEL_MODE, mode, 11);
    u_model.conv_half(1'b1, val(0));
    u_model.set_line(1'b0);
    n0 = strobes;
    for (int k = 0; k < 12; k++) begin
      u_model.conv_half(1'b0, 16'h0000);
      hi = bus_o;
      c = (mode[1:0] == CFG_PIX_GO || mode[1:0] == CFG_PIX_RGB) ? 2'((k + 1) % 3) : 2'h0;
      `CHK("channel", channel_o, c)
      `CHK("gain_sel", gain_o, gtab[c])
      u_model.wait_n(8);
      u_model.conv_half(1'b1, val(k + 1));
      j = k - lat;
      e = val(j);
      // Triple pixel mode: red live, green and blue held from the red fall
      if (mode[1:0] == CFG_PIX_RGB) begin
        e = val(j - j % 3);
        if (j % 3 == 1) e = ~e;
        if (j % 3 == 2) e = e ^ 16'h0F0F;
      end
      e = e ^ {16{mode[MODE_INVERT]}};
      if (k >= lat) begin
        `CHK("result", {hi, bus_o}, e)
      end
      u_model.wait_n(8);
    end
    `CHK("strobes", strobes - n0, 12)
    u_model.set_line(1'b1);
    `CHK("bus_oe", bus_oe_o, 1'b0)
    `CHK("chan_line", channel_o, CH_RED)
  endtask : stream
  // Main sequence
  initial begin
    errors = 0;
    tests_run = 0;
    rst_i = 1'b1;
    repeat (12) @(negedge clock_i);
    rst_i = 1'b0;
    u_model.wait_n(4);
    `CHK("gain_rst", gain_o, GAIN_RESET)
    `CHK("ofs_rst", offset_o, OFS_RESET)
    `CHK("mode_rst", {power_down_o, offset_range_o, dc_ref_ext_o, inverted_o}, 4'h0)
    `CHK("cfg_rst", {ac_coupled_o, signal_config_o, channel_o}, 5'h00)
    u_model.send_word(SEL_RED_GAIN, 8'hA8, 11);
    `CHK("gain", gain_o, 6'h2A)
    u_model.send_word(SEL_RED_OFS, 8'h5A, 11);
    `CHK("ofs", offset_o, 8'h5A)
    u_model.send_word(SEL_RED_OFS, 8'h11, 10);
    `CHK("ofs_short", offset_o, 8'h5A)
    u_model.send_word(SEL_RED_OFS, 8'h33, 13);
    `CHK("ofs_long", offset_o, 8'h33)
    u_model.send_word(SEL_MODE, 8'h3C, 11);
    `CHK("mode", {offset_range_o, dc_ref_ext_o, ac_coupled_o, inverted_o}, 4'hF)
    u_model.send_word(SEL_GRN_GAIN, 8'h54, 11);
    u_model.send_word(SEL_BLU_GAIN, 8'hFC, 11);
    stream(8'h00, LAT_LINE);
    stream(8'h01, LAT_PIXEL);
    stream(8'h02, LAT_PIXEL);
    stream(8'h04, LAT_LINE);
    u_model.send_word(SEL_MODE, 8'h81, 11);
    `CHK("pd_cfg", {power_down_o, signal_config_o}, 3'h4)
    u_model.set_line(1'b0);
    `CHK("pd_oe", bus_oe_o, 1'b0)
    u_model.set_line(1'b1);
    u_model.send_word(SEL_MODE, 8'h00, 11);
    `CHK("pd_keep", {power_down_o, gain_o, offset_o}, 15'h2A33)
    u_model.send_word(SEL_MODE, 8'h03, 11);
    u_model.set_line(1'b0);
    `CHK("line_chan", channel_o, CH_GRN)
    u_model.set_line(1'b1);
    u_model.set_line(1'b0);
    `CHK("line_gain", gain_o, gtab[CH_BLU])
    u_model.set_line(1'b1);
    u_model.send_word(SEL_MODE, 8'h40, 11);
    `CHK("dig_rst", {gain_o, offset_o}, {GAIN_RESET, OFS_RESET})
    u_model.set_clamp(1'b1);
    `CHK("clamp", clamp_active_o, 1'b1)
    u_model.set_clamp(1'b0);
    `CHK("track", clamp_active_o, 1'b0)
    test_done();
  end
  // Watchdog against a hang
  initial begin
    #100000;
    errors++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
